// ---- adcsc_regs.vh ----
`ifndef ADCSC_REGS_VH
`define ADCSC_REGS_VH

////////////////////////////////////////////////////////////////////////
// Register addresses
`define ADCSC_ADDR_W          16
`define ADCSC_ADDR_RES_HIGH   16'hffc4
`define ADCSC_ADDR_RES_LOW    16'hffc5
`define ADCSC_ADDR_MODE       16'hffc6
`define ADCSC_ADDR_START      16'hffc7
`define ADCSC_ADDR_CLK_STOP   16'hfffa

////////////////////////////////////////////////////////////////////////
// Reset values
`define ADCSC_MODE_RST        8'h30
`define ADCSC_START_RST       8'h7f
`define ADCSC_CLK_STOP_RST    8'hff
`define ADCSC_UNMAPPED_RD     8'hff

////////////////////////////////////////////////////////////////////////
// Mode register fields
`define ADCSC_MODE_SPEED_BIT  7
`define ADCSC_MODE_TRIG_BIT   6
`define ADCSC_MODE_FIXED_ONES 2'h3
`define ADCSC_MODE_CH_MSB     3
`define ADCSC_MODE_CH_LSB     0

////////////////////////////////////////////////////////////////////////
// Start register, clock stop register fields
`define ADCSC_START_BUSY_BIT  7
`define ADCSC_START_FIXED     7'h7f
`define ADCSC_CLK_STOP_BIT    4

////////////////////////////////////////////////////////////////////////
// Channel field codes
`define ADCSC_CH_GRP_LOW      2'h1
`define ADCSC_CH_GRP_HIGH     2'h2
`define ADCSC_RES_LOW_PAD     6'h00

////////////////////////////////////////////////////////////////////////
// Conversion timing, in system clocks: period = sample + 10 * step
`define ADCSC_RES_W           10
`define ADCSC_PERIOD_SLOW     62
`define ADCSC_PERIOD_FAST     31
`define ADCSC_SAMP_SLOW       3'h2
`define ADCSC_SAMP_FAST       3'h1
`define ADCSC_STEP_SLOW       3'h6
`define ADCSC_STEP_FAST       3'h3
`define ADCSC_SAR_MSB         4'h9
`define ADCSC_SAR_FIRST       10'h200

`endif

// ---- adcsc_trig.v ----
`include "adcsc_regs.vh"

module adcsc_trig (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst_n,
  // Controls
  input  wire ext_trigger_enable,
  input  wire irq_four_pin_function,
  input  wire trigger_edge_bit,
  // Pin and event
  input  wire ext_trigger_pin,
  output reg  trig_pulse_q
);

  reg  pin_prev_q;
  wire rise;
  wire fall;
  wire armed;

  assign rise  = ext_trigger_pin & ~pin_prev_q;
  assign fall  = ~ext_trigger_pin & pin_prev_q;
  assign armed = ext_trigger_enable & irq_four_pin_function;

  // Reset takes the pin level so a high pin is no false edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_prev_q   <= ext_trigger_pin;
      trig_pulse_q <= 1'b0;
    end else begin
      pin_prev_q   <= ext_trigger_pin;
      // Edge bit 1 picks rising, 0 falling
      trig_pulse_q <= armed & (trigger_edge_bit ? rise : fall);
    end
  end

endmodule

// ---- adcsc_sar.v ----
`include "adcsc_regs.vh"

module adcsc_sar (
  // Clock and reset
  input  wire                      ref_clk,
  input  wire                      rst_n,
  // Control
  input  wire                      start,
  input  wire                      abort,
  input  wire                      hold,
  input  wire                      speed,
  // Comparator side
  input  wire                      cmp_hi,
  output reg  [`ADCSC_RES_W-1:0]   code_q,
  output reg                       sample_q,
  // Completion
  output reg                       done_q
);

  reg        active_q;
  reg        fast_q;
  reg  [2:0] cnt_q;
  reg  [3:0] bit_q;
  reg  [`ADCSC_RES_W-1:0] code_d;
  wire [2:0] samp_len;
  wire [2:0] step_len;

  assign samp_len = fast_q ? `ADCSC_SAMP_FAST : `ADCSC_SAMP_SLOW;
  assign step_len = fast_q ? `ADCSC_STEP_FAST : `ADCSC_STEP_SLOW;

  // Keep the tried bit per comparator, try the next one down
  always @* begin
    code_d = code_q;
    code_d[bit_q] = cmp_hi;
    if (bit_q != 4'h0)
      code_d[bit_q - 4'h1] = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      fast_q   <= 1'b0;
      cnt_q    <= 3'h0;
      bit_q    <= `ADCSC_SAR_MSB;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
      code_q   <= {`ADCSC_RES_W{1'b0}};
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        active_q <= 1'b0;
        sample_q <= 1'b0;
      end else if (start && !active_q) begin
        active_q <= 1'b1;
        fast_q   <= speed;
        sample_q <= 1'b1;
        cnt_q    <= 3'h0;
        bit_q    <= `ADCSC_SAR_MSB;
        code_q   <= `ADCSC_SAR_FIRST;
      end else if (active_q && !hold) begin
        // Hold freezes mid-step; no progress without the clock
        if (sample_q) begin
          if (cnt_q == samp_len - 3'h1) begin
            sample_q <= 1'b0;
            cnt_q    <= 3'h0;
          end else
            cnt_q <= cnt_q + 3'h1;
        end else if (cnt_q == step_len - 3'h1) begin
          cnt_q  <= 3'h0;
          code_q <= code_d;
          bit_q  <= bit_q - 4'h1;
          if (bit_q == 4'h0) begin
            active_q <= 1'b0;
            done_q   <= 1'b1;
          end
        end else
          cnt_q <= cnt_q + 3'h1;
      end
    end
  end

endmodule

// ---- adcsc_ctrl.v ----
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "adcsc_regs.vh"

module adcsc_ctrl (
  // Clock and reset
  input  wire                     ref_clk,
  input  wire                     rst_n,
  // Register port
  input  wire [`ADCSC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata_q,
  // Bits held by other units
  input  wire                     trigger_edge_bit,
  input  wire                     irq_four_pin_function,
  input  wire                     conv_done_irq_enable,
  input  wire                     conv_done_request_clear,
  input  wire                     low_power_hold,
  // Trigger pin
  input  wire                     ext_trigger_pin,
  // Analog front end
  input  wire                     cmp_hi,
  output wire [`ADCSC_RES_W-1:0]  dac_code,
  output wire                     sample_hold,
  output reg  [7:0]               channel_enable_q,
  output wire                     converter_standby_ctrl,
  // Interrupt request
  output reg                      conv_done_request_flag_q,
  output wire                     conv_done_irq
);

  ////////////////////////////////////////////////////////////////////////
  // State

  reg        conv_speed_select_q;
  reg        ext_trigger_enable_q;
  reg  [3:0] channel_select_field_q;
  reg        start_busy_flag_q;
  reg  [7:0] module_clock_stop_one_q;
  reg  [`ADCSC_RES_W-1:0] result_q;
  reg  [7:0] rdata_d;
  reg  [7:0] channel_enable_d;

  // Slices of the documented reset word keep every field consistent
  localparam [7:0] mode_rst_val = `ADCSC_MODE_RST;

  wire       wr_mode;
  wire       wr_start;
  wire       wr_clk_stop;
  wire       standby;
  wire       hold;
  wire       trig_pulse;
  wire       sw_start;
  wire       sw_stop;
  wire       start_now;
  wire       sar_done;
  wire [`ADCSC_RES_W-1:0] sar_code;
  wire [7:0] mode_rd;
  wire [7:0] start_rd;
  wire [7:0] res_high_rd;
  wire [7:0] res_low_rd;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  assign wr_mode     = reg_wr & (reg_addr == `ADCSC_ADDR_MODE);
  assign wr_start    = reg_wr & (reg_addr == `ADCSC_ADDR_START);
  assign wr_clk_stop = reg_wr & (reg_addr == `ADCSC_ADDR_CLK_STOP);

  assign standby = ~module_clock_stop_one_q[`ADCSC_CLK_STOP_BIT];
  assign converter_standby_ctrl = module_clock_stop_one_q[`ADCSC_CLK_STOP_BIT];
  // Standby or a low power mode stops the converter clock
  assign hold = standby | low_power_hold;

  ////////////////////////////////////////////////////////////////////////
  // Start and stop

  adcsc_trig u_trig (
    .ref_clk               (ref_clk),
    .rst_n                 (rst_n),
    .ext_trigger_enable    (ext_trigger_enable_q),
    .irq_four_pin_function (irq_four_pin_function),
    .trigger_edge_bit      (trigger_edge_bit),
    .ext_trigger_pin       (ext_trigger_pin),
    .trig_pulse_q          (trig_pulse)
  );

  assign sw_start = wr_start & reg_wdata[`ADCSC_START_BUSY_BIT];
  assign sw_stop  = wr_start & ~reg_wdata[`ADCSC_START_BUSY_BIT];
  // Busy masks both sources so a running conversion is untouched
  assign start_now = (sw_start | trig_pulse) & ~start_busy_flag_q
                     & ~hold;

  adcsc_sar u_sar (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (start_now),
    .abort    (sw_stop & ~sar_done),
    .hold     (hold),
    .speed    (conv_speed_select_q),
    .cmp_hi   (cmp_hi),
    .code_q   (sar_code),
    .sample_q (sample_hold),
    .done_q   (sar_done)
  );

  // Mid-conversion value is the trial code, not a result
  assign dac_code = sar_code;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_speed_select_q    <= mode_rst_val[`ADCSC_MODE_SPEED_BIT];
      ext_trigger_enable_q   <= mode_rst_val[`ADCSC_MODE_TRIG_BIT];
      channel_select_field_q <= mode_rst_val[3:0];
      start_busy_flag_q      <= 1'b0;
    end else begin
      // Mode register is frozen while held; a stop write still clears busy
      if (wr_mode && !hold) begin
        conv_speed_select_q    <= reg_wdata[`ADCSC_MODE_SPEED_BIT];
        ext_trigger_enable_q   <= reg_wdata[`ADCSC_MODE_TRIG_BIT];
        // No interlock: a change while busy is the caller's fault
        channel_select_field_q <= reg_wdata[3:0];
      end
      // Completion wins over a stop written in the same cycle
      if (sar_done)
        start_busy_flag_q <= 1'b0;
      else if (sw_stop)
        start_busy_flag_q <= 1'b0;
      else if (start_now)
        start_busy_flag_q <= 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      module_clock_stop_one_q <= `ADCSC_CLK_STOP_RST;
    else if (wr_clk_stop)
      module_clock_stop_one_q <= reg_wdata;
  end

  // No reset: result survives chip reset
  always @(posedge ref_clk) begin
    if (sar_done)
      result_q <= sar_code;
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion request

  always @(posedge ref_clk) begin
    if (!rst_n)
      conv_done_request_flag_q <= 1'b0;
    else if (sar_done)
      conv_done_request_flag_q <= 1'b1;
    else if (conv_done_request_clear)
      conv_done_request_flag_q <= 1'b0;
  end

  assign conv_done_irq = conv_done_request_flag_q
                         & conv_done_irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // Channel decode

  always @* begin
    channel_enable_d = 8'h00;
    case (channel_select_field_q[3:2])
      `ADCSC_CH_GRP_LOW:
        channel_enable_d[{1'b0, channel_select_field_q[1:0]}] = 1'b1;
      `ADCSC_CH_GRP_HIGH:
        channel_enable_d[{1'b1, channel_select_field_q[1:0]}] = 1'b1;
      default:
        channel_enable_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      channel_enable_q <= 8'h00;
    else
      channel_enable_q <= channel_enable_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  assign mode_rd = {conv_speed_select_q, ext_trigger_enable_q,
                    `ADCSC_MODE_FIXED_ONES, channel_select_field_q};
  assign start_rd = {start_busy_flag_q, `ADCSC_START_FIXED};
  assign res_high_rd = result_q[9:2];
  assign res_low_rd  = {result_q[1:0], `ADCSC_RES_LOW_PAD};

  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ADCSC_ADDR_MODE:     rdata_d = mode_rd;
        `ADCSC_ADDR_START:    rdata_d = start_rd;
        `ADCSC_ADDR_RES_HIGH: rdata_d = res_high_rd;
        `ADCSC_ADDR_RES_LOW:  rdata_d = res_low_rd;
        `ADCSC_ADDR_CLK_STOP: rdata_d = module_clock_stop_one_q;
        default:              rdata_d = `ADCSC_UNMAPPED_RD;
      endcase
    end
  end

  // Data valid only in the cycle after the read strobe
  always @(posedge ref_clk) begin
    if (!rst_n)
      reg_rdata_q <= 8'h00;
    else
      reg_rdata_q <= rdata_d;
  end

endmodule

// ---- adcsc_ain_model.sv ----
module adcsc_ain_model (
  // Converter side
  input  logic [9:0] dac_code,
  input  logic [7:0] channel_enable_q,
  // Comparator
  output logic       cmp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] lvl;

  // Input k sits at k*146+1, so input 7 is full scale
  always_comb begin
    lvl = 10'h000;
    for (int k = 0; k < 8; k++)
      if (channel_enable_q[k]) lvl = 10'(k * 146 + 1);
  end
  // No input selected: comparator sees ground
  assign cmp_hi = (channel_enable_q != 8'h00) && (lvl >= dac_code);
endmodule

// ---- adcsc_ctrl_assertions.sv ----
`include "adcsc_regs.vh"
module adcsc_chk (
  // Clock and reset
  input logic                     ref_clk,
  input logic                     rst_n,
  // Register port
  input logic [`ADCSC_ADDR_W-1:0] reg_addr,
  input logic                     reg_rd,
  input logic [7:0]               reg_rdata_q,
  // Converter
  input logic                     conv_done_irq_enable,
  input logic                     conv_done_request_clear,
  input logic [`ADCSC_RES_W-1:0]  dac_code,
  input logic                     sample_hold,
  input logic [7:0]               channel_enable_q,
  input logic                     converter_standby_ctrl,
  input logic                     conv_done_request_flag_q,
  input logic                     conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  chk_mode_ones: assert property (
    s_rd(`ADCSC_ADDR_MODE) |=> reg_rdata_q[5:4] == 2'h3)
    else $error("mode fixed bits wrong");
  chk_start_ones: assert property (
    s_rd(`ADCSC_ADDR_START) |=> reg_rdata_q[6:0] == 7'h7f)
    else $error("start fixed bits wrong");
  chk_res_low_pad: assert property (
    s_rd(`ADCSC_ADDR_RES_LOW) |=> reg_rdata_q[5:0] == 6'h00)
    else $error("result low pad wrong");
  chk_irq_gate: assert property (
    conv_done_irq == (conv_done_request_flag_q && conv_done_irq_enable))
    else $error("request not gated by enable");
  chk_ch_onehot: assert property ($onehot0(channel_enable_q))
    else $error("input select not one-hot");
  chk_sar_first: assert property (
    $rose(sample_hold) |-> dac_code == `ADCSC_SAR_FIRST)
    else $error("first trial code wrong");
  chk_sample_len: assert property (
    $rose(sample_hold) |-> ##[1:2] !sample_hold)
    else $error("sampling too long");
  chk_standby_rst: assert property (
    $rose(rst_n) |-> converter_standby_ctrl)
    else $error("standby bit not one after reset");
  chk_flag_sticky: assert property (
    conv_done_request_flag_q && !conv_done_request_clear
      |=> conv_done_request_flag_q)
    else $error("request flag dropped");
endmodule

bind adcsc_ctrl adcsc_chk u_chk (.ref_clk, .rst_n, .reg_addr, .reg_rd,
  .reg_rdata_q, .conv_done_irq_enable, .conv_done_request_clear,
  .dac_code, .sample_hold, .channel_enable_q, .converter_standby_ctrl,
  .conv_done_request_flag_q, .conv_done_irq);

// ---- tb_top.sv ----
`include "adcsc_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, reg_wr, reg_rd, trigger_edge_bit;
  logic        irq_four_pin_function, conv_done_irq_enable, cmp_hi;
  logic        conv_done_request_clear, low_power_hold, ext_trigger_pin;
  logic        sample_hold, converter_standby_ctrl, conv_done_irq;
  logic        conv_done_request_flag_q;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, channel_enable_q;
  logic [9:0]  dac_code;
  int          err_total, n_compared;

  adcsc_ctrl uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .trigger_edge_bit, .irq_four_pin_function,
    .conv_done_irq_enable, .conv_done_request_clear, .low_power_hold,
    .ext_trigger_pin, .cmp_hi, .dac_code, .sample_hold, .channel_enable_q,
    .converter_standby_ctrl, .conv_done_request_flag_q, .conv_done_irq);
  adcsc_ain_model u_ain (.dac_code, .channel_enable_q, .cmp_hi);

  always #2.5 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Extra edge after each strobe keeps drivers single-assigned
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e);
    @(posedge ref_clk);
  endtask
  task automatic wflag(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 200) begin
        chk(1'b0, 1'b1);
        test_done;
      end
    end while (conv_done_request_flag_q !== 1'b1);
    @(posedge ref_clk);
  endtask
  task automatic clr;
    conv_done_request_clear <= 1'b1;
    @(posedge ref_clk);
    conv_done_request_clear <= 1'b0;
    @(posedge ref_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(channel_enable_q, 8'h00);
    rd(`ADCSC_ADDR_MODE, 8'h30);
    rd(`ADCSC_ADDR_START, 8'h7f);
    rd(`ADCSC_ADDR_CLK_STOP, 8'hff);
    rd(16'h0000, 8'hff);
    wr(`ADCSC_ADDR_MODE, 8'h00);
    rd(`ADCSC_ADDR_MODE, 8'h30);
    wr(`ADCSC_ADDR_MODE, 8'hcf);
    // Input select is registered: look after the edge has settled
    #1 chk(channel_enable_q, 8'h00);
    @(posedge ref_clk);
    wr(`ADCSC_ADDR_START, 8'h00);
    rd(`ADCSC_ADDR_START, 8'h7f);
    wr(`ADCSC_ADDR_CLK_STOP, 8'hef);
    chk(converter_standby_ctrl, 1'b0);
    wr(`ADCSC_ADDR_CLK_STOP, 8'hff);
    chk(converter_standby_ctrl, 1'b1);
  endtask
  task automatic t_conv(input int k);
    logic [9:0] v;
    int         n, p;
    v = 10'(k * 146 + 1);
    p = k[0] ? `ADCSC_PERIOD_FAST : `ADCSC_PERIOD_SLOW;
    conv_done_irq_enable <= k[1];
    // Speed and input change only while idle
    wr(`ADCSC_ADDR_MODE, {k[0], 3'h3, k[2], ~k[2], k[1:0]});
    #1 chk(channel_enable_q, 8'h01 << k);
    @(posedge ref_clk);
    wr(`ADCSC_ADDR_START, 8'h80);
    wr(`ADCSC_ADDR_START, 8'h80);
    rd(`ADCSC_ADDR_START, 8'hff);
    wflag(n);
    chk(n >= p - 6 && n <= p - 2, 1'b1);
    chk(conv_done_irq, k[1]);
    rd(`ADCSC_ADDR_START, 8'h7f);
    rd(`ADCSC_ADDR_RES_HIGH, v[9:2]);
    rd(`ADCSC_ADDR_RES_LOW, {v[1:0], 6'h00});
    clr;
  endtask
  task automatic t_abort;
    wr(`ADCSC_ADDR_MODE, 8'h34);
    wr(`ADCSC_ADDR_START, 8'h80);
    wr(`ADCSC_ADDR_START, 8'h00);
    rd(`ADCSC_ADDR_START, 8'h7f);
    repeat (70) @(posedge ref_clk);
    #1 chk(conv_done_request_flag_q, 1'b0);
    @(posedge ref_clk);
    rd(`ADCSC_ADDR_RES_HIGH, 8'hff);
  endtask
  // Standby refuses a start; a low power hold freezes a running one
  task automatic t_hold;
    int n;
    wr(`ADCSC_ADDR_MODE, 8'h34);
    wr(`ADCSC_ADDR_CLK_STOP, 8'hef);
    wr(`ADCSC_ADDR_START, 8'h80);
    rd(`ADCSC_ADDR_START, 8'h7f);
    wr(`ADCSC_ADDR_CLK_STOP, 8'hff);
    wr(`ADCSC_ADDR_START, 8'h80);
    // Hold only after sampling, so the sample window stays short
    repeat (4) @(posedge ref_clk);
    low_power_hold <= 1'b1;
    repeat (80) @(posedge ref_clk);
    rd(`ADCSC_ADDR_START, 8'hff);
    low_power_hold <= 1'b0;
    wflag(n);
    chk(n > 50, 1'b1);
    rd(`ADCSC_ADDR_RES_HIGH, 8'h00);
    clr;
  endtask
  // Wrong edge first, then the selected edge
  task automatic t_trig(input logic en, pf, e, x);
    int n;
    ext_trigger_pin <= e;
    irq_four_pin_function <= pf;
    trigger_edge_bit <= e;
    repeat (3) @(posedge ref_clk);
    wr(`ADCSC_ADDR_MODE, {1'b1, en, 2'h3, 4'h4});
    ext_trigger_pin <= ~e;
    repeat (4) @(posedge ref_clk);
    rd(`ADCSC_ADDR_START, 8'h7f);
    ext_trigger_pin <= e;
    repeat (4) @(posedge ref_clk);
    rd(`ADCSC_ADDR_START, {x, 7'h7f});
    if (x) begin
      wflag(n);
      clr;
    end
    wr(`ADCSC_ADDR_MODE, 8'hb4);
  endtask
  task automatic t_rst;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(`ADCSC_ADDR_MODE, 8'h30);
    rd(`ADCSC_ADDR_START, 8'h7f);
    rd(`ADCSC_ADDR_RES_LOW, 8'h40);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {ref_clk, rst_n, reg_wr, reg_rd, trigger_edge_bit} = 5'h00;
    {irq_four_pin_function, conv_done_irq_enable, low_power_hold} = 3'h0;
    {conv_done_request_clear, ext_trigger_pin} = 2'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    for (int k = 0; k < 8; k++) t_conv(k);
    t_abort;
    t_hold;
    t_trig(1'b0, 1'b1, 1'b1, 1'b0);
    t_trig(1'b1, 1'b0, 1'b1, 1'b0);
    t_trig(1'b1, 1'b1, 1'b1, 1'b1);
    t_trig(1'b1, 1'b1, 1'b0, 1'b1);
    t_rst;
    test_done;
  end
endmodule
